// file: cob_bank.sv
// charger option bank: factory codes, host registers, enable logic
// assumes an i2c host on scl and sda, analog comparators on pins
`timescale 1ns/1ps
module cob_bank
  import cob_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR     = DEF_DEV_ADDR,
  parameter logic [2:0] OPT_TERM_V   = DEF_TERM_V,
  parameter logic [2:0] OPT_FAST_I   = DEF_FAST_I,
  parameter logic [2:0] OPT_EOC_I    = DEF_EOC_I,
  parameter logic [1:0] OPT_TRICKLE  = DEF_TRICKLE,
  parameter logic       OPT_VARIANT  = 1'b0,
  parameter logic       OPT_THERM_R  = DEF_THERM_R,
  parameter logic [3:0] OPT_BETA     = DEF_BETA,
  parameter logic       OPT_STANDBY  = DEF_STANDBY,
  parameter logic       OPT_TMR_FLT  = DEF_TMR_FAULT
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        input_supply_ok,
  input  wire logic        regulator_active,
  input  wire logic        system_voltage_ok,
  input  wire logic        battery_above_weak,
  input  wire logic        system_below_battery,
  input  wire logic        timer_timeout,
  output logic             system_enable_output,
  output logic             battery_iso_off,
  output logic             ideal_diode_on,
  output logic             charging_active,
  output logic             regulator_off,
  output logic             recharge_allowed,
  output logic             watchdog_on,
  output logic             standby_low_power,
  output logic             standby_mode_select,
  output logic             thermal_profile_on,
  output logic             thermal_profile_pick,
  output logic             charge_volt_cap_on,
  output logic [1:0]       charge_volt_cap_level,
  output logic [12:0]      term_voltage_mv,
  output logic [10:0]      fast_charge_ma,
  output logic [9:0]       eoc_current_ma_x10,
  output logic [11:0]      trickle_mv,
  output logic [12:0]      system_voltage_mv,
  output logic [6:0]       thermistor_kohm,
  output logic [12:0]      thermistor_beta
);
  // decode of termination voltage code
  function automatic logic [12:0] term_mv(input logic [2:0] c);
    case (c)
      3'h2:    term_mv = 13'he74;
      3'h3:    term_mv = 13'hed8;
      3'h4:    term_mv = 13'hf3c;
      3'h5:    term_mv = 13'hfa0;
      3'h6:    term_mv = 13'h1004;
      3'h7:    term_mv = 13'h1130;
      default: term_mv = 13'h1068;
    endcase
  endfunction

  // decode of fast charge current code
  function automatic logic [10:0] fast_ma(input logic [2:0] c);
    case (c)
      3'h0:    fast_ma = 11'h1f4;
      3'h1:    fast_ma = 11'h12c;
      3'h2:    fast_ma = 11'h226;
      3'h3:    fast_ma = 11'h258;
      3'h4:    fast_ma = 11'h2ee;
      3'h5:    fast_ma = 11'h384;
      default: fast_ma = 11'h514;
    endcase
  endfunction

  // decode of trickle to fast threshold code
  function automatic logic [11:0] trk_mv(input logic [1:0] c);
    case (c)
      2'h0:    trk_mv = 12'h9c4;
      2'h1:    trk_mv = 12'h7d0;
      2'h2:    trk_mv = 12'hb54;
      default: trk_mv = 12'ha28;
    endcase
  endfunction

  // decode of thermistor beta code, unlisted codes give zero
  function automatic logic [12:0] beta_val(input logic [3:0] c);
    case (c)
      4'h4:    beta_val = 13'hc4e;
      4'h5:    beta_val = 13'hd16;
      4'h6:    beta_val = 13'hdac;
      4'h7:    beta_val = 13'he42;
      4'h8:    beta_val = 13'hf0a;
      4'h9:    beta_val = 13'hfa0;
      4'ha:    beta_val = 13'h1068;
      4'hb:    beta_val = 13'h1130;
      default: beta_val = 13'h0000;
    endcase
  endfunction

  typedef struct packed {
    logic [7:0]  r_vcap;
    logic [7:0]  r_rch;
    logic [7:0]  r_twd;
    logic [7:0]  r_func;
    logic [7:0]  r_tdio;
    logic [7:0]  r_sysen;
    logic        fault;
    logic        sysen;
    logic        iso_off;
    logic        diode;
    logic        chg;
    logic        reg_off;
    logic [12:0] term;
    logic [10:0] fast;
    logic [9:0]  eoc;
    logic [11:0] trk;
    logic [12:0] sysv;
    logic [6:0]  kohm;
    logic [12:0] beta;
  } cob_bank_t;

  // factory codes fixed at build, loaded with the registers
  localparam logic [2:0] OPT_SYSV = OPT_VARIANT ? DEF_SYSV_TWO : DEF_SYSV_ONE;
  localparam cob_bank_t RST_S = '{
    r_vcap:  RST_VOLT_CAP,
    r_rch:   RST_RECHARGE,
    r_twd:   RST_TIMER_WD,
    r_func:  RST_FUNC,
    r_tdio:  RST_THERM_DIO,
    r_sysen: RST_SYSTEM_ENABLE_CONFIG,
    fault:   1'b0,
    sysen:   1'b0,
    iso_off: 1'b0,
    diode:   1'b0,
    chg:     1'b0,
    reg_off: 1'b0,
    term:    13'h0000,
    fast:    11'h000,
    eoc:     10'h000,
    trk:     12'h000,
    sysv:    13'h0000,
    kohm:    7'h00,
    beta:    13'h0000
  };

  cob_bank_t q;
  cob_bank_t d;
  cob_link_if lnk();
  logic [6:0] raw;
  logic [6:0] syn;
  logic       supply_s;
  logic       regact_s;
  logic       sysok_s;
  logic       weak_ok_s;
  logic       below_s;
  logic [1:0] sel;
  logic [1:0] dio;
  logic       mon;
  logic       chg_on;

  // all pins except timer_timeout pass two flip-flops before use
  assign raw = {scl_i, sda_i, input_supply_ok, regulator_active,
                system_voltage_ok, battery_above_weak, system_below_battery};
  cob_sync #(
    .W (7)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (raw),
    .dout   (syn)
  );
  assign lnk.scl   = syn[6];
  assign lnk.sda   = syn[5];
  assign supply_s  = syn[4];
  assign regact_s  = syn[3];
  assign sysok_s   = syn[2];
  assign weak_ok_s = syn[1];
  assign below_s   = syn[0];

  // serial engine
  cob_i2c_eng #(
    .DEV_ADDR (DEV_ADDR)
  ) u_eng (
    .clk    (clk),
    .arst_n (arst_n),
    .l      (lnk)
  );

  // read mux, unmapped addresses read zero
  always_comb begin
    case (lnk.addr)
      OFS_VOLT_CAP:  lnk.rdata = q.r_vcap;
      OFS_RECHARGE:  lnk.rdata = q.r_rch;
      OFS_TIMER_WD:  lnk.rdata = q.r_twd;
      OFS_FUNC:      lnk.rdata = q.r_func;
      OFS_THERM_DIO: lnk.rdata = q.r_tdio;
      OFS_SYSTEM_ENABLE_CONFIG:    lnk.rdata = q.r_sysen;
      default:       lnk.rdata = 8'h00;
    endcase
  end

  // current field views
  assign sel    = q.r_sysen[POS_SYSEN +: 2];
  assign dio    = q.r_tdio[POS_DIODE +: 2];
  assign mon    = q.r_func[BIT_BATT_MON_ON];
  assign chg_on = q.r_func[BIT_CHARGE_ON];

  // register writes, fault flag and enable outputs
  always_comb begin
    d = q;
    if (lnk.wr) begin
      case (lnk.addr)
        OFS_VOLT_CAP:  d.r_vcap  = lnk.wdata;
        OFS_RECHARGE:  d.r_rch   = lnk.wdata;
        OFS_TIMER_WD:  d.r_twd   = lnk.wdata;
        OFS_FUNC:      d.r_func  = lnk.wdata;
        OFS_THERM_DIO: d.r_tdio  = lnk.wdata;
        OFS_SYSTEM_ENABLE_CONFIG:    d.r_sysen = lnk.wdata;
        default: ;
      endcase
    end
    // host clearing charge on also clears the fault; a timeout wins
    if (lnk.wr && lnk.addr == OFS_FUNC && !lnk.wdata[BIT_CHARGE_ON]) begin
      d.fault = 1'b0;
    end
    if (timer_timeout) begin
      d.fault = 1'b1;
    end
    // charging stops on timeout, regulator follows option
    d.chg     = chg_on & ~q.fault;
    d.reg_off = q.fault & ~OPT_TMR_FLT;
    // ideal diode select
    case (dio)
      DIODE_PLAIN: d.diode = below_s;
      DIODE_WEAK:  d.diode = below_s & weak_ok_s;
      default:     d.diode = 1'b0;
    endcase
    // system enable select
    d.iso_off = 1'b0;
    case (sel)
      SYSEN_REG: d.sysen = regact_s & sysok_s;
      SYSEN_BATT: d.sysen = weak_ok_s;
      SYSEN_WEAK: begin
        if (!supply_s && mon) begin
          d.sysen   = ~weak_ok_s;
          d.iso_off = ~weak_ok_s;
        end else begin
          d.sysen = regact_s & sysok_s;
        end
      end
      SYSEN_MIX: d.sysen = chg_on ? weak_ok_s : regact_s;
      default: d.sysen = 1'b0;
    endcase
    // factory option decode
    d.term = term_mv(OPT_TERM_V);
    d.fast = fast_ma(OPT_FAST_I);
    d.eoc  = (OPT_EOC_I == DEF_EOC_I) ? 10'h20d : 10'h000;
    d.trk  = trk_mv(OPT_TRICKLE);
    d.sysv = 13'h10cc + 13'(OPT_SYSV) * 13'h0064;
    d.kohm = OPT_THERM_R ? 7'h64 : 7'h0a;
    d.beta = beta_val(OPT_BETA);
  end

  // state register, defaults on power-on reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  // open drain data pin, low only
  assign sda_o  = 1'b0;
  assign sda_oe = lnk.sda_oe;

  // outputs from the state register, standby_mode_select straight from its option
  assign system_enable_output = q.sysen;
  assign battery_iso_off      = q.iso_off;
  assign ideal_diode_on       = q.diode;
  assign charging_active      = q.chg;
  assign regulator_off        = q.reg_off;
  assign recharge_allowed     = ~q.r_rch[BIT_RECHARGE_OFF];
  assign watchdog_on          = q.r_twd[BIT_WATCHDOG_ON];
  assign standby_low_power    = q.r_func[BIT_STANDBY_LP];
  assign standby_mode_select  = OPT_STANDBY;
  assign thermal_profile_on   = q.r_tdio[BIT_THERM_ON];
  assign thermal_profile_pick = q.r_tdio[BIT_THERM_PICK];
  assign charge_volt_cap_on   = q.r_tdio[BIT_VCAP_ON];
  assign charge_volt_cap_level = q.r_vcap[POS_VCAP +: 2];
  assign term_voltage_mv      = q.term;
  assign fast_charge_ma       = q.fast;
  assign eoc_current_ma_x10   = q.eoc;
  assign trickle_mv           = q.trk;
  assign system_voltage_mv    = q.sysv;
  assign thermistor_kohm      = q.kohm;
  assign thermistor_beta      = q.beta;
endmodule

// file: cob_bank_chk.sv
// port checker for the option bank: decodes, timer fault, enable relations
// assumes default factory options apart from the timer fault choice
`timescale 1ns/1ps
module cob_bank_chk
  import cob_pkg::*;
#(
  parameter logic OPT_TMR_FLT = DEF_TMR_FAULT
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        sda_o,
  input wire logic        input_supply_ok,
  input wire logic        system_below_battery,
  input wire logic        timer_timeout,
  input wire logic        system_enable_output,
  input wire logic        battery_iso_off,
  input wire logic        ideal_diode_on,
  input wire logic        charging_active,
  input wire logic        regulator_off,
  input wire logic        recharge_allowed,
  input wire logic        watchdog_on,
  input wire logic        standby_mode_select,
  input wire logic [12:0] term_voltage_mv,
  input wire logic [10:0] fast_charge_ma,
  input wire logic [9:0]  eoc_current_ma_x10,
  input wire logic [11:0] trickle_mv,
  input wire logic [12:0] system_voltage_mv,
  input wire logic [6:0]  thermistor_kohm,
  input wire logic [12:0] thermistor_beta
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // decoded factory options hold from the second edge after release
  a_dec_volt: assert property ($past(arst_n) |->
    term_voltage_mv == 13'h1068 && trickle_mv == 12'h9c4 && system_voltage_mv == 13'h1388)
    else $error("voltage decode off");
  a_dec_curr: assert property ($past(arst_n) |->
    fast_charge_ma == 11'h2ee && eoc_current_ma_x10 == 10'h20d) else $error("current decode off");
  a_dec_therm: assert property ($past(arst_n) |->
    thermistor_kohm == 7'h0a && thermistor_beta == 13'hc4e && !standby_mode_select)
    else $error("thermistor decode off");
  // host registers start at their defaults
  a_reset_vals: assert property ($rose(arst_n) |->
    recharge_allowed && !watchdog_on && !charging_active) else $error("reset values off");
  // timer timeout stops charging, regulator follows the fault option
  a_stop_chg: assert property (timer_timeout |-> ##[1:4] !charging_active)
    else $error("charging kept after timeout");
  a_reg_keep: assert property (timer_timeout |-> ##[1:4] regulator_off == !OPT_TMR_FLT)
    else $error("regulator action wrong after timeout");
  // diode only conducts with the system below the battery
  a_diode_cause: assert property (ideal_diode_on |-> $past(system_below_battery, 2) ||
    $past(system_below_battery, 3) || $past(system_below_battery, 4))
    else $error("diode on without cause");
  // isolation only in weak mode, which drives enable too and needs no supply
  a_iso_sysen: assert property (battery_iso_off |-> system_enable_output)
    else $error("isolation without enable");
  a_iso_supply: assert property ($past(input_supply_ok, 2) && $past(input_supply_ok, 3) &&
    $past(input_supply_ok, 4) |-> !battery_iso_off) else $error("isolation with supply");
  a_open_drain: assert property (sda_o == 1'b0) else $error("data pin driven high");
  c_timeout: cover property (timer_timeout ##1 !charging_active);
  c_isolate: cover property (battery_iso_off);
  c_diode: cover property (ideal_diode_on ##1 !ideal_diode_on);
endmodule

// file: cob_host.sv
// i2c host model: open-drain master that pulls scl and sda low
// assumes pull-ups on both lines; paced by the bank clock falling edge
`timescale 1ns/1ps
module cob_host
  import cob_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEF_DEV_ADDR
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic     scl_low,
  output logic     sda_low
);
  localparam int HALF = 10;
  // both lines released at start
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bit, data set in low phase, sampled mid high phase
  task automatic put_bit(input logic b, output logic r);
    sda_low = !b;
    hold(4);
    scl_low = 1'b0;
    hold(5);
    r = sda_line;
    hold(5);
    scl_low = 1'b1;
    hold(4);
  endtask
  // start or repeated start, leaves scl low
  task automatic start;
    sda_low = 1'b0;
    hold(4);
    scl_low = 1'b0;
    hold(HALF);
    sda_low = 1'b1;
    hold(HALF);
    scl_low = 1'b1;
    hold(4);
  endtask
  task automatic stop;
    sda_low = 1'b1;
    hold(4);
    scl_low = 1'b0;
    hold(HALF);
    sda_low = 1'b0;
    hold(HALF);
  endtask
  // eight bits msb first, then the ninth bit released by the host
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], r);
      rx[i] = r;
    end
    put_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic write_reg(input logic [7:0] ra, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a1, a2, a3;
    start();
    xfer({DEV_ADDR, 1'b0}, rx, a1);
    xfer(ra, rx, a2);
    xfer(d, rx, a3);
    stop();
    ok = a1 && a2 && a3;
  endtask
  // pointer write, repeated start, one byte read, nack and stop
  task automatic read_reg(input logic [7:0] ra, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a1, a2, a3, na;
    start();
    xfer({DEV_ADDR, 1'b0}, rx, a1);
    xfer(ra, rx, a2);
    start();
    xfer({DEV_ADDR, 1'b1}, rx, a3);
    xfer(8'hff, d, na);
    stop();
    ok = a1 && a2 && a3;
  endtask
endmodule

// file: cob_i2c_eng.sv
// i2c slave engine: address match, pointer, byte read and write
// assumes scl and sda arrive synchronised through the link
`timescale 1ns/1ps
module cob_i2c_eng
  import cob_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEF_DEV_ADDR
) (
  input  wire logic clk,
  input  wire logic arst_n,
  cob_link_if.eng   l
);
  typedef struct packed {
    cob_i2c_st_t st;
    logic [3:0]  bitcnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        rw;
    logic        ack;
    logic        oe;
    logic        wr;
    logic        scl_p;
    logic        sda_p;
  } cob_eng_t;
  cob_eng_t q;
  cob_eng_t d;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  // bus conditions from the synchronised levels
  assign rise  = l.scl & ~q.scl_p;
  assign fall  = ~l.scl & q.scl_p;
  assign start = l.scl & q.scl_p & q.sda_p & ~l.sda;
  assign stop  = l.scl & q.scl_p & ~q.sda_p & l.sda;
  // protocol state machine
  always_comb begin
    d       = q;
    d.wr    = 1'b0;
    d.scl_p = l.scl;
    d.sda_p = l.sda;
    if (start) begin
      d.st     = ST_ADDR;
      d.bitcnt = 4'h0;
      d.oe     = 1'b0;
    end else if (stop) begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
    end else if (rise) begin
      case (q.st)
        ST_ADDR, ST_REG, ST_WDATA: begin
          d.sh     = {q.sh[6:0], l.sda};
          d.bitcnt = q.bitcnt + 4'h1;
        end
        ST_RDATA: d.bitcnt = q.bitcnt + 4'h1;
        ST_RACK: begin
          d.ack = ~l.sda;
          if (!l.sda) begin
            d.ptr = q.ptr + 8'h01;
          end
        end
        default: ;
      endcase
    end else if (fall) begin
      case (q.st)
        ST_ADDR: begin
          if (q.bitcnt == BYTE_BITS) begin
            if (q.sh[7:1] == DEV_ADDR) begin
              d.st = ST_AACK;
              d.oe = 1'b1;
              d.rw = q.sh[0];
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        ST_REG: begin
          if (q.bitcnt == BYTE_BITS) begin
            d.ptr = q.sh;
            d.st  = ST_RACK_DEV;
            d.oe  = 1'b1;
          end
        end
        ST_WDATA: begin
          if (q.bitcnt == BYTE_BITS) begin
            d.wr = 1'b1;
            d.st = ST_WACK;
            d.oe = 1'b1;
          end
        end
        ST_AACK, ST_RACK: begin
          d.bitcnt = 4'h0;
          d.oe     = 1'b0;
          if ((q.st == ST_AACK && q.rw) || (q.st == ST_RACK && q.ack)) begin
            d.st = ST_RDATA;
            d.sh = l.rdata;
            d.oe = ~l.rdata[7];
          end else if (q.st == ST_AACK) begin
            d.st = ST_REG;
          end else begin
            d.st = ST_IDLE;
          end
        end
        ST_RACK_DEV, ST_WACK: begin
          d.bitcnt = 4'h0;
          d.oe     = 1'b0;
          d.st     = ST_WDATA;
          if (q.st == ST_WACK) begin
            d.ptr = q.ptr + 8'h01;
          end
        end
        ST_RDATA: begin
          if (q.bitcnt == BYTE_BITS) begin
            d.oe = 1'b0;
            d.st = ST_RACK;
          end else if (q.bitcnt != 4'h0) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign l.sda_oe = q.oe;
  assign l.wr     = q.wr;
  assign l.addr   = q.ptr;
  assign l.wdata  = q.sh;
endmodule

// file: cob_link_if.sv
// link between the bank and its serial engine
// assumes pin levels are already synchronised
`timescale 1ns/1ps
interface cob_link_if;
  logic       scl;
  logic       sda;
  logic       sda_oe;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport eng  (input scl, sda, rdata, output sda_oe, wr, addr, wdata);
  modport bank (output scl, sda, rdata, input sda_oe, wr, addr, wdata);
endinterface

// file: cob_pkg.sv
// constants and types of the charger option bank
// assumes a single 40 MHz clock and an i2c host on two pins
package cob_pkg;
  // register offsets
  localparam logic [7:0] OFS_VOLT_CAP   = 8'h03;
  localparam logic [7:0] OFS_RECHARGE   = 8'h05;
  localparam logic [7:0] OFS_TIMER_WD   = 8'h06;
  localparam logic [7:0] OFS_FUNC       = 8'h07;
  localparam logic [7:0] OFS_THERM_DIO  = 8'h08;
  localparam logic [7:0] OFS_SYSTEM_ENABLE_CONFIG     = 8'h11;
  // field positions
  localparam int BIT_RECHARGE_OFF = 7;
  localparam int BIT_WATCHDOG_ON  = 2;
  localparam int BIT_STANDBY_LP   = 6;
  localparam int BIT_BATT_MON_ON  = 5;
  localparam int BIT_CHARGE_ON    = 0;
  localparam int BIT_THERM_ON     = 7;
  localparam int BIT_THERM_PICK   = 6;
  localparam int BIT_VCAP_ON      = 5;
  localparam int POS_DIODE        = 3;
  localparam int POS_SYSEN        = 0;
  localparam int POS_VCAP         = 0;
  // register reset values
  localparam logic [7:0] RST_VOLT_CAP  = 8'h00;
  localparam logic [7:0] RST_RECHARGE  = 8'h00;
  localparam logic [7:0] RST_TIMER_WD  = 8'h00;
  localparam logic [7:0] RST_FUNC      = 8'h00;
  localparam logic [7:0] RST_THERM_DIO = 8'h00;
  localparam logic [7:0] RST_SYSTEM_ENABLE_CONFIG    = 8'h00;
  // factory option defaults
  localparam logic [2:0] DEF_TERM_V    = 3'h0;
  localparam logic [2:0] DEF_FAST_I    = 3'h4;
  localparam logic [2:0] DEF_EOC_I     = 3'h0;
  localparam logic [1:0] DEF_TRICKLE   = 2'h0;
  localparam logic [2:0] DEF_SYSV_ONE  = 3'h7;
  localparam logic [2:0] DEF_SYSV_TWO  = 3'h0;
  localparam logic       DEF_THERM_R   = 1'b0;
  localparam logic [3:0] DEF_BETA      = 4'h4;
  localparam logic       DEF_STANDBY   = 1'b0;
  localparam logic       DEF_TMR_FAULT = 1'b1;
  // bus address, value arbitrary
  localparam logic [6:0] DEF_DEV_ADDR  = 7'h2a;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  // system enable select codes
  localparam logic [1:0] SYSEN_REG  = 2'h0;
  localparam logic [1:0] SYSEN_BATT = 2'h1;
  localparam logic [1:0] SYSEN_WEAK = 2'h2;
  localparam logic [1:0] SYSEN_MIX  = 2'h3;
  // ideal diode codes
  localparam logic [1:0] DIODE_PLAIN = 2'h0;
  localparam logic [1:0] DIODE_WEAK  = 2'h1;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK_DEV,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } cob_i2c_st_t;
endpackage

// file: cob_sync.sv
// two flip-flop synchroniser for a group of pins
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
module cob_sync
  import cob_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cob_sync_t;
  cob_sync_t q;
  cob_sync_t d;
  // first stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign dout = q.s2;
endmodule

// file: test_cob_bank.sv
// top bench of the option bank: resets, drives i2c and comparator pins
// assumes the checker and host model files are compiled first
`timescale 1ns/1ps
module test_cob_bank;
  import cob_pkg::*;
  localparam int LIMIT = 90000;
  logic clk, arst_n, scl_low, sda_low, sda_o, sda_oe, input_supply_ok, battery_above_weak;
  logic system_below_battery, timer_timeout, system_enable_output, battery_iso_off;
  logic ideal_diode_on, charging_active, regulator_off, recharge_allowed, watchdog_on, ok;
  logic standby_low_power, standby_mode_select, thermal_profile_on, thermal_profile_pick;
  logic charge_volt_cap_on, regulator_active = 1'b1, system_voltage_ok = 1'b1;
  logic [1:0]  charge_volt_cap_level;
  logic [12:0] term_voltage_mv, system_voltage_mv, thermistor_beta;
  logic [10:0] fast_charge_ma;
  logic [9:0]  eoc_current_ma_x10;
  logic [11:0] trickle_mv;
  logic [6:0]  thermistor_kohm;
  logic [7:0]  rd;
  int          n_fail, compares, cyc;
  // wired lines with pull-ups
  wire scl_line = !scl_low;
  wire sda_line = !(sda_low || (sda_oe && !sda_o));
  cob_bank dut (.clk, .arst_n, .scl_i(scl_line), .sda_i(sda_line), .sda_o, .sda_oe,
    .input_supply_ok, .regulator_active, .system_voltage_ok, .battery_above_weak,
    .system_below_battery, .timer_timeout, .system_enable_output, .battery_iso_off,
    .ideal_diode_on, .charging_active, .regulator_off, .recharge_allowed, .watchdog_on,
    .standby_low_power, .standby_mode_select, .thermal_profile_on, .thermal_profile_pick,
    .charge_volt_cap_on, .charge_volt_cap_level, .term_voltage_mv, .fast_charge_ma,
    .eoc_current_ma_x10, .trickle_mv, .system_voltage_mv, .thermistor_kohm, .thermistor_beta);
  cob_host host (.clk, .sda_line, .scl_low, .sda_low);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    host.write_reg(ra, d, ok);
    chk(16'(ok), 16'h1);
  endtask
  task automatic rdchk(input logic [7:0] ra, input logic [7:0] exp);
    host.read_reg(ra, rd, ok);
    chk(16'(ok), 16'h1);
    chk(16'(rd), 16'(exp));
  endtask
  // defaults after power-on, an unmapped place included
  task automatic t_reset_state;
    logic [7:0] ra [7] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h04};
    for (int i = 0; i < 7; i++) rdchk(ra[i], 8'h00);
    chk(16'(recharge_allowed), 16'h1);
    chk(16'(watchdog_on), 16'h0);
    chk(16'(term_voltage_mv), 16'h1068);
    chk(16'(fast_charge_ma), 16'h02ee);
    chk(16'(eoc_current_ma_x10), 16'h020d);
    chk(16'(trickle_mv), 16'h09c4);
    chk(16'(system_voltage_mv), 16'h1388);
    chk(16'(thermistor_kohm), 16'h000a);
    chk(16'(thermistor_beta), 16'h0c4e);
    chk(16'(standby_mode_select), 16'h0);
  endtask
  // write, field outputs, read back, then a second reset
  task automatic t_regs;
    logic [7:0] ra [5] = '{8'h05, 8'h06, 8'h03, 8'h08, 8'h04};
    logic [7:0] dv [5] = '{8'h80, 8'h04, 8'h02, 8'he0, 8'h5a};
    for (int i = 0; i < 5; i++) wr(ra[i], dv[i]);
    chk(16'(recharge_allowed), 16'h0);
    chk(16'(watchdog_on), 16'h1);
    chk(16'({thermal_profile_on, thermal_profile_pick, charge_volt_cap_on}), 16'h7);
    chk(16'(charge_volt_cap_level), 16'h2);
    for (int i = 0; i < 5; i++) rdchk(ra[i], (i == 4) ? 8'h00 : dv[i]);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rdchk(8'h05, 8'h00);
  endtask
  // charge enable and timer timeout
  task automatic t_charge;
    wr(8'h07, 8'h01);
    chk(16'(charging_active), 16'h1);
    timer_timeout = 1'b1;
    @(negedge clk);
    timer_timeout = 1'b0;
    settle();
    chk(16'(charging_active), 16'h0);
    chk(16'(regulator_off), 16'h0);
    wr(8'h07, 8'h00);
    wr(8'h07, 8'h01);
    chk(16'(charging_active), 16'h1);
    wr(8'h07, 8'h40);
    chk(16'(charging_active), 16'h0);
    chk(16'(standby_low_power), 16'h1);
  endtask
  // every ideal diode code against the weak comparator
  task automatic t_diode;
    system_below_battery = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 8'(c << 3));
      for (int w = 0; w < 2; w++) begin
        battery_above_weak = w[0];
        settle();
        chk(16'(ideal_diode_on), 16'((c == 0) || (c == 1 && w == 1)));
      end
    end
    system_below_battery = 1'b0;
    wr(8'h08, 8'h00);
    settle();
    chk(16'(ideal_diode_on), 16'h0);
  endtask
  task automatic se(input logic [7:0] code, input logic sup, input logic [7:0] f07,
                    input logic w, input logic es, input logic ei);
    wr(8'h11, code);
    wr(8'h07, f07);
    input_supply_ok = sup;
    battery_above_weak = w;
    settle();
    chk(16'({system_enable_output, battery_iso_off}), 16'({es, ei}));
  endtask
  // every enable select code, weak mode with and without its conditions
  task automatic t_sysen;
    se(8'h00, 1'b1, 8'h00, 1'b0, 1'b1, 1'b0);
    se(8'h01, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0);
    se(8'h01, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0);
    se(8'h02, 1'b0, 8'h20, 1'b0, 1'b1, 1'b1);
    se(8'h02, 1'b0, 8'h20, 1'b1, 1'b0, 1'b0);
    se(8'h02, 1'b1, 8'h20, 1'b0, 1'b1, 1'b0);
    se(8'h02, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
    se(8'h03, 1'b1, 8'h00, 1'b0, 1'b1, 1'b0);
    se(8'h03, 1'b1, 8'h01, 1'b0, 1'b0, 1'b0);
    se(8'h03, 1'b1, 8'h01, 1'b1, 1'b1, 1'b0);
    system_voltage_ok = 1'b0;
    se(8'h00, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0);
    regulator_active = 1'b0;
    se(8'h03, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0);
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    input_supply_ok = 1'b1;
    battery_above_weak = 1'b1;
    system_below_battery = 1'b0;
    timer_timeout = 1'b0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset_state();
    t_regs();
    t_charge();
    t_diode();
    t_sysen();
    summarize();
  end
endmodule
bind cob_bank cob_bank_chk #(.OPT_TMR_FLT(OPT_TMR_FLT)) chk_i (.clk, .arst_n, .sda_o,
  .input_supply_ok, .system_below_battery, .timer_timeout, .system_enable_output,
  .battery_iso_off, .ideal_diode_on, .charging_active, .regulator_off, .recharge_allowed,
  .watchdog_on, .standby_mode_select, .term_voltage_mv, .fast_charge_ma, .eoc_current_ma_x10,
  .trickle_mv, .system_voltage_mv, .thermistor_kohm, .thermistor_beta);
